// ---- design/rtccs_map.svh ----
// Register offsets, field positions, reset values and timing counts of the timekeeping unit.
`ifndef RTCCS_MAP_SVH
`define RTCCS_MAP_SVH
`define RTCCS_OFF_CLOCK_CONFIG_LOW     8'h00
`define RTCCS_OFF_HALF_SECOND_PERIOD   8'h01
`define RTCCS_OFF_POWER_WINDOW_TIMING  8'h02
`define RTCCS_OFF_CLOCK_STATUS_LOW     8'h03
`define RTCCS_OFF_SECONDS_VALUE        8'h04
`define RTCCS_OFF_HOURS_MINUTES_VALUE  8'h05
`define RTCCS_OFF_ALARM_SECONDS        8'h06
`define RTCCS_OFF_ALARM_HOURS_MINUTES  8'h07
`define RTCCS_OFF_CAPTURE_A_SECONDS    8'h08
`define RTCCS_OFF_CAPTURE_A_HOURS_MIN  8'h09
`define RTCCS_OFF_CAPTURE_B_SECONDS    8'h0A
`define RTCCS_OFF_CAPTURE_B_HOURS_MIN  8'h0B
`define RTCCS_OFF_CONTROL              8'h0C
`define RTCCS_OFF_UNLOCK_KEY           8'h0D
`define RTCCS_CFG_WRITE_MASK           16'hF8_F3
`define RTCCS_SEC_WRITE_MASK           16'h7F_00
`define RTCCS_HM_WRITE_MASK            16'h3F_7F
`define RTCCS_CTRL_GUARD_BIT           11
`define RTCCS_CTRL_WRITE_MASK          16'h08_00
`define RTCCS_STAT_ALARM_BIT           5
`define RTCCS_STAT_CAP_B_BIT           4
`define RTCCS_STAT_CAP_A_BIT           3
`define RTCCS_PERIOD_RESET             16'h3F_FF
`define RTCCS_KEY_FIRST                8'h55
`define RTCCS_KEY_SECOND               8'hAA
`define RTCCS_TRIM_HALVES              5'd31
`endif

// ---- design/rtccs_pkg.sv ----
// Types shared by the timekeeping unit files.
package rtccs_pkg;
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [15:0] wdata;
    } rtccs_bus_s;

    typedef enum logic [2:0] {
        KEY_IDLE  = 3'b001,
        KEY_FIRST = 3'b010,
        KEY_OPEN  = 3'b100
    } rtccs_key_e;

    typedef enum logic [2:0] {
        WIN_IDLE   = 3'b001,
        WIN_STABLE = 3'b010,
        WIN_SAMPLE = 3'b100
    } rtccs_win_e;
endpackage

// ---- design/rtccs_prescaler.sv ----
// Selectable 1/16/64/256 tick prescaler.
`timescale 1ns/1ps
module rtccs_prescaler (
    // Clock and reset
    input  wire logic       clock_in,
    input  wire logic       resetn_in,
    // Control
    input  wire logic       tick_in,
    input  wire logic [1:0] select_in,
    // Result
    output logic            tick_out
);
    typedef struct packed {
        logic [7:0] count;
    } rtccs_ps_s;
    rtccs_ps_s state_ff;
    rtccs_ps_s nxt_state;
    logic [7:0] limit;

    always_comb begin
        case (select_in)
            2'b00:   limit = 8'h00;
            2'b01:   limit = 8'h0F;
            2'b10:   limit = 8'h3F;
            default: limit = 8'hFF;
        endcase
        nxt_state = state_ff;
        if (tick_in) begin
            nxt_state.count = (state_ff.count >= limit) ? 8'h00 : state_ff.count + 8'h01;
        end
    end

    assign tick_out = tick_in && (state_ff.count >= limit);

    always_ff @(posedge clock_in) begin
        if (!resetn_in) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end
endmodule // rtccs_prescaler

// ---- design/rtccs_core.sv ----
// Timekeeping unit: clock setup, divider, power window timing, status flags and time registers.
`timescale 1ns/1ps
`include "rtccs_map.svh"
module rtccs_core (
    // Clock and reset
    input  wire logic                clock_in,
    input  wire logic                resetn_in,
    // Register port
    input  wire rtccs_pkg::rtccs_bus_s bus_in,
    output logic [15:0]              rdata_out,
    // Tick sources
    input  wire logic                secondary_oscillator_in,
    input  wire logic                low_power_rc_oscillator_in,
    input  wire logic                power_line_clock_pin_in,
    input  wire logic                peripheral_tick_in,
    // Events
    input  wire logic                alarm_event_in,
    input  wire logic                capture_a_event_in,
    input  wire logic                capture_b_event_in,
    input  wire logic                alarm_busy_in,
    input  wire logic                sample_in,
    // Window status
    output logic                     sample_gated_out,
    output logic                     stability_active_out,
    output logic                     half_period_phase_out
);
    typedef struct packed {
        logic [3:0]  src_meta;
        logic [3:0]  src_sync;
        logic [3:0]  src_last;
        logic [3:0]  evt_meta;
        logic [3:0]  evt_sync;
        logic [1:0]  cap_last;
        logic [15:0] cfg;
        logic [15:0] period;
        logic [15:0] pwt;
        logic [15:0] count;
        logic        trim_pending;
        logic [4:0]  trim_left;
        logic [4:0]  halves;
        logic        guard;
        rtccs_pkg::rtccs_key_e key;
        rtccs_pkg::rtccs_win_e win;
        logic [7:0]  win_count;
        logic        alarm_flag;
        logic        cap_a_flag;
        logic        cap_b_flag;
        logic        cap_a_req;
        logic        cap_b_req;
        logic        syncing;
        logic        half;
        logic [15:0] time_sec;
        logic [15:0] time_hm;
        logic [15:0] alm_sec;
        logic [15:0] alm_hm;
        logic [15:0] cap_a_sec;
        logic [15:0] cap_a_hm;
        logic [15:0] cap_b_sec;
        logic [15:0] cap_b_hm;
        logic [15:0] rdata;
        logic        gated;
    } rtccs_core_s;

    rtccs_core_s state_ff;
    rtccs_core_s nxt_state;
    logic        src_edge;
    logic        tk_tick;
    logic        pw_tick;
    logic [3:0]  src_rise;
    logic [15:0] status;
    logic        wr_sec;

    // Timekeeping and power-window prescalers share one module.
    rtccs_prescaler u_tk_ps (
        .clock_in  (clock_in),
        .resetn_in (resetn_in),
        .tick_in   (src_edge),
        .select_in (state_ff.cfg[5:4]),
        .tick_out  (tk_tick)
    );
    rtccs_prescaler u_pw_ps (
        .clock_in  (clock_in),
        .resetn_in (resetn_in),
        .tick_in   (src_edge),
        .select_in (state_ff.cfg[7:6]),
        .tick_out  (pw_tick)
    );

    assign src_rise  = state_ff.src_sync & ~state_ff.src_last;
    assign src_edge  = src_rise[state_ff.cfg[1:0]];
    assign status    = {10'h000, state_ff.alarm_flag, state_ff.cap_b_flag, state_ff.cap_a_flag,
                        state_ff.syncing, state_ff.evt_sync[3], state_ff.half};
    assign wr_sec    = bus_in.wr && (bus_in.addr == `RTCCS_OFF_SECONDS_VALUE);
    assign rdata_out = state_ff.rdata;
    assign sample_gated_out      = state_ff.gated;
    assign stability_active_out  = (state_ff.win == rtccs_pkg::WIN_STABLE);
    assign half_period_phase_out = state_ff.half;

    // BCD increment of one digit pair; returns carry in bit 8.
    function automatic logic [8:0] bcd_inc(input logic [7:0] v, input logic [7:0] top);
        logic [8:0] r;
        r = 9'h000;
        if (v == top) begin
            r = 9'h100;
        end else if (v[3:0] == 4'h9) begin
            r = {1'b0, v[7:4] + 4'h1, 4'h0};
        end else begin
            r = {1'b0, v[7:4], v[3:0] + 4'h1};
        end
        return r;
    endfunction

    always_comb begin
        logic       underflow;
        logic [8:0] s_inc;
        logic [8:0] m_inc;
        logic [8:0] h_next;
        logic [7:0] h_val;
        underflow = 1'b0;
        s_inc     = 9'h000;
        m_inc     = 9'h000;
        h_next    = 9'h000;
        h_val     = 8'h00;
        nxt_state = state_ff;
        // Every tick and event pin input except sample_in goes through two flops; edges are taken from the second only.
        nxt_state.src_meta = {peripheral_tick_in, power_line_clock_pin_in,
                              low_power_rc_oscillator_in, secondary_oscillator_in};
        nxt_state.src_sync = state_ff.src_meta;
        nxt_state.src_last = state_ff.src_sync;
        nxt_state.evt_meta = {alarm_busy_in, alarm_event_in, capture_b_event_in, capture_a_event_in};
        nxt_state.evt_sync = state_ff.evt_meta;
        nxt_state.cap_last = state_ff.evt_sync[1:0];
        nxt_state.syncing  = 1'b0;

        // Divider: extra trim cycles are spent after the sixteen-second boundary.
        if (tk_tick) begin
            if (state_ff.trim_pending) begin
                nxt_state.trim_left = state_ff.trim_left - 5'd1;
                nxt_state.trim_pending = (state_ff.trim_left != 5'd1);
            end else if (state_ff.count == 16'h0000) begin
                underflow = 1'b1;
                nxt_state.count = state_ff.period;
            end else begin
                nxt_state.count = state_ff.count - 16'h0001;
            end
        end
        nxt_state.syncing = tk_tick && (state_ff.count == 16'h0000) && !state_ff.trim_pending;

        if (underflow) begin
            nxt_state.half = ~state_ff.half;
            nxt_state.halves = (state_ff.halves == `RTCCS_TRIM_HALVES) ? 5'd0 : state_ff.halves + 5'd1;
            if (state_ff.halves == `RTCCS_TRIM_HALVES && state_ff.cfg[15:11] != 5'd0) begin
                nxt_state.trim_pending = 1'b1;
                nxt_state.trim_left = state_ff.cfg[15:11];
            end
            if (state_ff.half) begin
                s_inc = bcd_inc({1'b0, state_ff.time_sec[14:8]}, 8'h59);
                nxt_state.time_sec[14:8] = s_inc[6:0];
                if (s_inc[8]) begin
                    m_inc = bcd_inc({1'b0, state_ff.time_hm[6:0]}, 8'h59);
                    nxt_state.time_hm[6:0] = m_inc[6:0];
                    if (m_inc[8]) begin
                        h_val = {2'b00, state_ff.time_hm[13:8]};
                        h_next = bcd_inc(h_val, 8'h23);
                        nxt_state.time_hm[13:8] = h_next[5:0];
                    end
                end
            end
        end

        // Power window: stability first, then the sample window.
        case (state_ff.win)
            rtccs_pkg::WIN_IDLE: begin
                if (state_ff.pwt[7:0] != 8'h00) begin
                    nxt_state.win = rtccs_pkg::WIN_STABLE;
                    nxt_state.win_count = state_ff.pwt[7:0];
                end
            end
            rtccs_pkg::WIN_STABLE: begin
                if (pw_tick) begin
                    if (state_ff.win_count == 8'h01) begin
                        nxt_state.win = rtccs_pkg::WIN_SAMPLE;
                        nxt_state.win_count = state_ff.pwt[15:8];
                    end else begin
                        nxt_state.win_count = state_ff.win_count - 8'h01;
                    end
                end
            end
            rtccs_pkg::WIN_SAMPLE: begin
                if (pw_tick && state_ff.pwt[15:8] != 8'hFF) begin
                    if (state_ff.win_count <= 8'h01) begin
                        nxt_state.win = rtccs_pkg::WIN_IDLE;
                    end else begin
                        nxt_state.win_count = state_ff.win_count - 8'h01;
                    end
                end
            end
            default: nxt_state.win = rtccs_pkg::WIN_IDLE;
        endcase
        if (state_ff.pwt[15:8] == 8'hFF) begin
            nxt_state.gated = !sample_in ? 1'b0 : 1'b0;
        end else if (state_ff.pwt[15:8] == 8'h00) begin
            nxt_state.gated = 1'b1;
        end else begin
            nxt_state.gated = (nxt_state.win != rtccs_pkg::WIN_SAMPLE);
        end

        // Unlock key sequence: the open state lasts exactly one cycle.
        case (state_ff.key)
            rtccs_pkg::KEY_IDLE: begin
                if (bus_in.wr && bus_in.addr == `RTCCS_OFF_UNLOCK_KEY && bus_in.wdata[7:0] == `RTCCS_KEY_FIRST) begin
                    nxt_state.key = rtccs_pkg::KEY_FIRST;
                end
            end
            rtccs_pkg::KEY_FIRST: begin
                if (bus_in.wr && bus_in.addr == `RTCCS_OFF_UNLOCK_KEY && bus_in.wdata[7:0] == `RTCCS_KEY_SECOND) begin
                    nxt_state.key = rtccs_pkg::KEY_OPEN;
                end else if (bus_in.wr) begin
                    nxt_state.key = rtccs_pkg::KEY_IDLE;
                end
            end
            rtccs_pkg::KEY_OPEN: nxt_state.key = rtccs_pkg::KEY_IDLE;
            default:             nxt_state.key = rtccs_pkg::KEY_IDLE;
        endcase

        // Register writes.
        if (bus_in.wr) begin
            if (bus_in.addr == `RTCCS_OFF_CLOCK_CONFIG_LOW) begin
                nxt_state.cfg = bus_in.wdata & `RTCCS_CFG_WRITE_MASK;
            end else if (bus_in.addr == `RTCCS_OFF_HALF_SECOND_PERIOD) begin
                if (state_ff.guard) begin
                    nxt_state.period = bus_in.wdata;
                end
            end else if (bus_in.addr == `RTCCS_OFF_POWER_WINDOW_TIMING) begin
                nxt_state.pwt = bus_in.wdata;
                nxt_state.win = rtccs_pkg::WIN_IDLE;
            end else if (bus_in.addr == `RTCCS_OFF_CLOCK_STATUS_LOW) begin
                // Writing 1 requests a capture (capture A only while its flag is clear); writing 0 clears the flag.
                if (bus_in.wdata[`RTCCS_STAT_CAP_A_BIT] && !state_ff.cap_a_flag) begin
                    nxt_state.cap_a_req = 1'b1;
                end
                if (bus_in.wdata[`RTCCS_STAT_CAP_B_BIT]) begin
                    nxt_state.cap_b_req = 1'b1;
                end
                if (!bus_in.wdata[`RTCCS_STAT_ALARM_BIT]) begin
                    nxt_state.alarm_flag = 1'b0;
                end
                if (!bus_in.wdata[`RTCCS_STAT_CAP_A_BIT]) begin
                    nxt_state.cap_a_flag = 1'b0;
                end
                if (!bus_in.wdata[`RTCCS_STAT_CAP_B_BIT]) begin
                    nxt_state.cap_b_flag = 1'b0;
                end
            end else if (wr_sec) begin
                nxt_state.time_sec = bus_in.wdata & `RTCCS_SEC_WRITE_MASK;
                nxt_state.half = 1'b0;
            end else if (bus_in.addr == `RTCCS_OFF_HOURS_MINUTES_VALUE) begin
                nxt_state.time_hm = bus_in.wdata & `RTCCS_HM_WRITE_MASK;
            end else if (bus_in.addr == `RTCCS_OFF_ALARM_SECONDS) begin
                nxt_state.alm_sec = bus_in.wdata & `RTCCS_SEC_WRITE_MASK;
            end else if (bus_in.addr == `RTCCS_OFF_ALARM_HOURS_MINUTES) begin
                nxt_state.alm_hm = bus_in.wdata & `RTCCS_HM_WRITE_MASK;
            end else if (bus_in.addr == `RTCCS_OFF_CONTROL) begin
                if (bus_in.wdata[`RTCCS_CTRL_GUARD_BIT]) begin
                    nxt_state.guard = 1'b1;
                end else if (state_ff.key == rtccs_pkg::KEY_OPEN) begin
                    nxt_state.guard = 1'b0;
                end
            end
        end

        // Captures; a set in the same cycle as a clear wins for capture B and the alarm, but for capture A the clear wins.
        if ((state_ff.evt_sync[0] && !state_ff.cap_last[0]) || state_ff.cap_a_req) begin
            if (!state_ff.cap_a_flag) begin
                nxt_state.cap_a_sec = nxt_state.time_sec;
                nxt_state.cap_a_hm  = nxt_state.time_hm;
                nxt_state.cap_a_flag = 1'b1;
            end
            nxt_state.cap_a_req = 1'b0;
        end
        if ((state_ff.evt_sync[1] && !state_ff.cap_last[1]) || state_ff.cap_b_req) begin
            nxt_state.cap_b_sec = nxt_state.time_sec;
            nxt_state.cap_b_hm  = nxt_state.time_hm;
            nxt_state.cap_b_flag = 1'b1;
            nxt_state.cap_b_req = 1'b0;
        end
        if (state_ff.evt_sync[2]) begin
            nxt_state.alarm_flag = 1'b1;
        end

        // Read data, registered; unmapped offsets read zero.
        nxt_state.rdata = 16'h0000;
        if (bus_in.rd) begin
            if (bus_in.addr == `RTCCS_OFF_CLOCK_CONFIG_LOW) begin
                nxt_state.rdata = state_ff.cfg;
            end else if (bus_in.addr == `RTCCS_OFF_HALF_SECOND_PERIOD) begin
                nxt_state.rdata = state_ff.period;
            end else if (bus_in.addr == `RTCCS_OFF_POWER_WINDOW_TIMING) begin
                nxt_state.rdata = state_ff.pwt;
            end else if (bus_in.addr == `RTCCS_OFF_CLOCK_STATUS_LOW) begin
                nxt_state.rdata = status;
            end else if (bus_in.addr == `RTCCS_OFF_SECONDS_VALUE) begin
                nxt_state.rdata = state_ff.time_sec;
            end else if (bus_in.addr == `RTCCS_OFF_HOURS_MINUTES_VALUE) begin
                nxt_state.rdata = state_ff.time_hm;
            end else if (bus_in.addr == `RTCCS_OFF_ALARM_SECONDS) begin
                nxt_state.rdata = state_ff.alm_sec;
            end else if (bus_in.addr == `RTCCS_OFF_ALARM_HOURS_MINUTES) begin
                nxt_state.rdata = state_ff.alm_hm;
            end else if (bus_in.addr == `RTCCS_OFF_CAPTURE_A_SECONDS) begin
                nxt_state.rdata = state_ff.cap_a_sec;
            end else if (bus_in.addr == `RTCCS_OFF_CAPTURE_A_HOURS_MIN) begin
                nxt_state.rdata = state_ff.cap_a_hm;
            end else if (bus_in.addr == `RTCCS_OFF_CAPTURE_B_SECONDS) begin
                nxt_state.rdata = state_ff.cap_b_sec;
            end else if (bus_in.addr == `RTCCS_OFF_CAPTURE_B_HOURS_MIN) begin
                nxt_state.rdata = state_ff.cap_b_hm;
            end else if (bus_in.addr == `RTCCS_OFF_CONTROL) begin
                nxt_state.rdata = {4'h0, state_ff.guard, 11'h000};
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (!resetn_in) begin
            state_ff        <= '0;
            state_ff.period <= `RTCCS_PERIOD_RESET;
            state_ff.key    <= rtccs_pkg::KEY_IDLE;
            state_ff.win    <= rtccs_pkg::WIN_IDLE;
            state_ff.gated  <= 1'b1;
        end else begin
            state_ff <= nxt_state;
        end
    end
endmodule // rtccs_core

// ---- dv/rtccs_core_asserts.sv ----
// Concurrent checks on the ports of the timekeeping unit.
`timescale 1ns/1ps
module rtccs_core_asserts (
    // Clock and reset
    input  wire logic                  clock_in,
    input  wire logic                  resetn_in,
    // Register port
    input  wire rtccs_pkg::rtccs_bus_s bus_in,
    input  wire logic [15:0]           rdata_out,
    // Events
    input  wire logic                  alarm_event_in,
    input  wire logic                  alarm_busy_in,
    // Window status
    input  wire logic                  sample_gated_out,
    input  wire logic                  stability_active_out,
    input  wire logic                  half_period_phase_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!resetn_in);
    logic rd_sec;
    logic rd_hm;
    logic rd_stat;
    logic wr_pwt;
    assign rd_sec  = bus_in.rd && (bus_in.addr == 8'h04);
    assign rd_hm   = bus_in.rd && (bus_in.addr == 8'h05);
    assign rd_stat = bus_in.rd && (bus_in.addr == 8'h03);
    assign wr_pwt  = bus_in.wr && (bus_in.addr == 8'h02);
    property p_sec_unused;
        rd_sec |=> (rdata_out[15] == 1'b0) && (rdata_out[7:0] == 8'h00);
    endproperty
    a_sec_unused: assert property (p_sec_unused) else $error("Seconds read shows unused bits set.");
    property p_hm_unused;
        rd_hm |=> (rdata_out[15:14] == 2'b00) && (rdata_out[7] == 1'b0);
    endproperty
    a_hm_unused: assert property (p_hm_unused) else $error("Hours read shows unused bits set.");
    property p_half_read;
        rd_stat |=> rdata_out[0] == $past(half_period_phase_out);
    endproperty
    a_half_read: assert property (p_half_read) else $error("Status bit 0 differs from phase.");
    property p_sec_wr;
        (bus_in.wr && (bus_in.addr == 8'h04)) |-> ##[1:2] !half_period_phase_out;
    endproperty
    a_sec_wr: assert property (p_sec_wr) else $error("Seconds write left phase high.");
    property p_ungate;
        (wr_pwt && (bus_in.wdata[15:8] == 8'hFF)) |-> ##[1:3] !sample_gated_out;
    endproperty
    a_ungate: assert property (p_ungate) else $error("Sample stays gated at all-ones.");
    property p_gate;
        (wr_pwt && (bus_in.wdata[15:8] == 8'h00)) |-> ##[1:3] sample_gated_out;
    endproperty
    a_gate: assert property (p_gate) else $error("Sample not gated at zero.");
    property p_no_stab;
        (wr_pwt && (bus_in.wdata[7:0] == 8'h00)) |-> ##[1:3] !stability_active_out;
    endproperty
    a_no_stab: assert property (p_no_stab) else $error("Stability window with zero length.");
    // Events are synchronised first, so four cycles of level are needed before the flag shows.
    property p_alarm;
        alarm_event_in [*4] ##0 rd_stat |=> rdata_out[5];
    endproperty
    a_alarm: assert property (p_alarm) else $error("Alarm flag not set.");
    property p_busy;
        alarm_busy_in [*4] ##0 rd_stat |=> rdata_out[1];
    endproperty
    a_busy: assert property (p_busy) else $error("Alarm busy not shown.");
endmodule // rtccs_core_asserts
bind rtccs_core rtccs_core_asserts rtccs_core_asserts_i (.clock_in(clock_in), .resetn_in(resetn_in),
    .bus_in(bus_in), .rdata_out(rdata_out), .alarm_event_in(alarm_event_in), .alarm_busy_in(alarm_busy_in),
    .sample_gated_out(sample_gated_out), .stability_active_out(stability_active_out),
    .half_period_phase_out(half_period_phase_out));

// ---- dv/tb_top.sv ----
// Self-checking testbench of the timekeeping unit.
`timescale 1ns/1ps
`define CHK(a, e) begin \
    tests_run++; \
    if ((a) !== (e)) begin \
        mismatches++; \
        $display("ERROR t=%0t got=%h exp=%h", $time, (a), (e)); \
    end \
end
module tb_top;
    typedef struct packed {
        logic [7:0]  a;
        logic [15:0] w;
        logic [15:0] e;
    } rtccs_row_s;
    logic                  clock_in;
    logic                  resetn_in;
    rtccs_pkg::rtccs_bus_s bus_s;
    logic [15:0]           rdata_out;
    logic                  ptick = 1'b0;
    logic                  tick_run;
    logic                  alarm_ev;
    logic                  cap_b;
    logic                  busy;
    logic                  gated;
    logic                  stab;
    logic                  half;
    logic [15:0]           d;
    int                    mismatches = 0;
    int                    tests_run = 0;
    rtccs_row_s rows [12] = '{'{8'h00, 16'hFFFF, 16'hF8F3}, '{8'h01, 16'h1234, 16'h3FFF},
        '{8'h0C, 16'hFFFF, 16'h0800}, '{8'h01, 16'h0004, 16'h0004}, '{8'h04, 16'hFFFF, 16'h7F00},
        '{8'h05, 16'hFFFF, 16'h3F7F}, '{8'h06, 16'hFFFF, 16'h7F00}, '{8'h07, 16'hFFFF, 16'h3F7F},
        '{8'h02, 16'h1234, 16'h1234}, '{8'h02, 16'hFF00, 16'hFF00}, '{8'h02, 16'h0000, 16'h0000},
        '{8'h20, 16'hFFFF, 16'h0000}};
    rtccs_core rtccs_core_i (.clock_in(clock_in), .resetn_in(resetn_in), .bus_in(bus_s), .rdata_out(rdata_out),
        .secondary_oscillator_in(1'b0), .low_power_rc_oscillator_in(1'b0), .power_line_clock_pin_in(1'b0),
        .peripheral_tick_in(ptick), .alarm_event_in(alarm_ev), .capture_a_event_in(1'b0),
        .capture_b_event_in(cap_b), .alarm_busy_in(busy), .sample_in(1'b0), .sample_gated_out(gated),
        .stability_active_out(stab), .half_period_phase_out(half));
    initial begin
        clock_in = 1'b0;
        forever #50 clock_in = ~clock_in;
    end
    // A peripheral tick that toggles on every falling clock edge keeps a half second short while still crossing the input synchroniser.
    always @(negedge clock_in) if (tick_run) ptick <= ~ptick;
    task automatic complete_run();
        if ((mismatches == 0) && (tests_run > 0)) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [15:0] w);
        @(negedge clock_in);
        bus_s.wr = 1'b1;
        bus_s.addr = a;
        bus_s.wdata = w;
        @(negedge clock_in);
        bus_s.wr = 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [15:0] r);
        @(negedge clock_in);
        bus_s.rd = 1'b1;
        bus_s.addr = a;
        @(negedge clock_in);
        bus_s.rd = 1'b0;
        r = rdata_out;
    endtask
    task automatic wait_half(input logic v);
        int n;
        n = 0;
        while ((half !== v) && (n < 400)) begin
            @(negedge clock_in);
            n++;
        end
        if (n >= 400) begin
            mismatches++;
            complete_run();
        end
    endtask
    initial begin
        resetn_in = 1'b0;
        bus_s = '0;
        tick_run = 1'b0;
        alarm_ev = 1'b0;
        cap_b = 1'b0;
        busy = 1'b0;
        repeat (4) @(negedge clock_in);
        resetn_in = 1'b1;
        `CHK({gated, stab, half}, 3'b100)
        rd_reg(8'h01, d);
        `CHK(d, 16'h3FFF)
        foreach (rows[i]) begin
            wr_reg(rows[i].a, rows[i].w);
            rd_reg(rows[i].a, d);
            `CHK(d, rows[i].e)
        end
        wr_reg(8'h00, 16'h0003);
        wr_reg(8'h05, 16'h2359);
        tick_run = 1'b1;
        wait_half(1'b1);
        wr_reg(8'h04, 16'h5900);
        `CHK(half, 1'b0)
        wait_half(1'b1);
        wait_half(1'b0);
        tick_run = 1'b0;
        rd_reg(8'h04, d);
        `CHK(d, 16'h0000)
        rd_reg(8'h05, d);
        `CHK(d, 16'h0000)
        // One stability tick, then the sample window must open on the very tick that ends it.
        wr_reg(8'h02, 16'h0201);
        @(negedge clock_in);
        `CHK({stab, gated}, 2'b11)
        tick_run = 1'b1;
        for (int k = 0; (k < 40) && (stab !== 1'b0); k++) @(negedge clock_in);
        tick_run = 1'b0;
        `CHK({stab, gated}, 2'b00)
        if (stab !== 1'b0) complete_run();
        wr_reg(8'h03, 16'h0008);
        alarm_ev = 1'b1;
        cap_b = 1'b1;
        busy = 1'b1;
        repeat (6) @(negedge clock_in);
        rd_reg(8'h03, d);
        `CHK(d & 16'h003E, 16'h003A)
        alarm_ev = 1'b0;
        repeat (4) @(negedge clock_in);
        wr_reg(8'h03, 16'h0000);
        rd_reg(8'h03, d);
        `CHK(d & 16'h003A, 16'h0002)
        wr_reg(8'h03, 16'h0020);
        rd_reg(8'h03, d);
        `CHK(d & 16'h0020, 16'h0000)
        wr_reg(8'h0C, 16'h0000);
        rd_reg(8'h0C, d);
        `CHK(d, 16'h0800)
        // The clearing write must be taken on the edge right after the second key; all three go on three edges in a row.
        @(negedge clock_in);
        bus_s.wr = 1'b1;
        bus_s.addr = 8'h0D;
        bus_s.wdata = 16'h0055;
        @(negedge clock_in);
        bus_s.wdata = 16'h00AA;
        @(negedge clock_in);
        bus_s.addr = 8'h0C;
        bus_s.wdata = 16'h0000;
        @(negedge clock_in);
        bus_s.wr = 1'b0;
        rd_reg(8'h0C, d);
        `CHK(d, 16'h0000)
        wr_reg(8'h01, 16'h0009);
        rd_reg(8'h01, d);
        `CHK(d, 16'h0004)
        complete_run();
    end
endmodule // tb_top
